// ===== rtl/pdrb_pkg.sv
package pdrb_pkg;

	// ------------------------------------------------------------
	// Command word layout
	// ------------------------------------------------------------
	localparam int          CMD_W        = 16;
	localparam int          CMD_RW_BIT   = 15;
	localparam int          ADDR_HI      = 14;
	localparam int          ADDR_LO      = 11;
	localparam int          DATA_HI      = 7;
	localparam int          DATA_LO      = 0;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [3:0]  ADDR_PULLDOWN = 4'h6;
	localparam logic [3:0]  ADDR_RDLDAC   = 4'h7;
	localparam logic [3:0]  ADDR_GPIOCFG  = 4'h8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          RD_EN_BIT    = 6;
	localparam int          SEL_HI       = 5;
	localparam int          SEL_LO       = 2;
	localparam int          MODE_HI      = 1;
	localparam int          MODE_LO      = 0;
	localparam int          BUSY_EN_BIT  = 8;
	localparam int          BUSY_PIN     = 7;
	localparam int          GPIOCFG_W    = 9;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  PULLDOWN_RST = 8'hff;
	localparam logic [8:0]  GPIOCFG_RST  = 9'h000;
	localparam logic [3:0]  SEL_RST      = 4'h0;

	// ------------------------------------------------------------
	// Readback select codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SEL_NOP      = 4'h0,
		SEL_DAC      = 4'h1,
		SEL_ADC      = 4'h2,
		SEL_FIRSTCFG = 4'h3,
		SEL_LASTCFG  = 4'hd,
		SEL_UNDEF    = 4'he,
		SEL_SWRESET  = 4'hf
	} pdrb_sel_t;

	// ------------------------------------------------------------
	// DAC load modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_IMMED   = 2'b00,
		MODE_HOLD    = 2'b01,
		MODE_COPYALL = 2'b10,
		MODE_UNDEF   = 2'b11
	} pdrb_mode_t;

endpackage

// ===== rtl/pdrb_dac_if.sv
`timescale 1ns/10ps
interface pdrb_dac_if #(
	parameter int NUM_CH   = 8,
	parameter int DAC_BITS = 12
);
	import pdrb_pkg::*;

	logic                         wr_valid;
	logic [$clog2(NUM_CH)-1:0]    wr_chan;
	logic [DAC_BITS-1:0]          wr_data;
	pdrb_mode_t                   load_mode;
	logic                         copy_all;
	logic [NUM_CH*DAC_BITS-1:0]   dac_value;
	logic                         update;

	modport ctrl (
		output wr_valid, wr_chan, wr_data, load_mode, copy_all,
		input  dac_value, update
	);
	modport bank (
		input  wr_valid, wr_chan, wr_data, load_mode, copy_all,
		output dac_value, update
	);
endinterface

// ===== rtl/pdrb_dac_bank.sv
`timescale 1ns/10ps
module pdrb_dac_bank
	import pdrb_pkg::*;
#(
	parameter int NUM_CH   = 8,
	parameter int DAC_BITS = 12
) (
	// Clocking
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   clk_en,
	// Control side
	pdrb_dac_if.bank    dac
);

	logic [DAC_BITS-1:0] in_ff  [NUM_CH];
	logic [DAC_BITS-1:0] dac_ff [NUM_CH];
	logic                update_ff;

	// Stored modes 10 and 11 both hold; a copy happens only on the write
	wire immed_load = dac.wr_valid && (dac.load_mode == MODE_IMMED);

	always_ff @(posedge clk) begin
		if (reset) begin
			update_ff <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				in_ff[i]  <= '0;
				dac_ff[i] <= '0;
			end
		end else if (clk_en) begin
			update_ff <= immed_load || dac.copy_all;
			if (dac.wr_valid)
				in_ff[dac.wr_chan] <= dac.wr_data;
			if (dac.copy_all) begin
				// Fresh write in the same cycle is carried through
				for (int i = 0; i < NUM_CH; i++)
					dac_ff[i] <= (dac.wr_valid && dac.wr_chan == i) ?
						dac.wr_data : in_ff[i];
			end else if (immed_load) begin
				dac_ff[dac.wr_chan] <= dac.wr_data;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++)
			dac.dac_value[i*DAC_BITS +: DAC_BITS] = dac_ff[i];
	end
	assign dac.update = update_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_copy_update: assert property (@(posedge clk) disable iff (reset)
		clk_en && dac.copy_all |=> update_ff)
		else $error("copy-all did not raise update");

	chk_hold_stable: assert property (@(posedge clk) disable iff (reset)
		clk_en && dac.wr_valid && !dac.copy_all &&
		dac.load_mode == MODE_HOLD |=> $stable(dac.dac_value) && !update_ff)
		else $error("hold mode changed a DAC register");

endmodule

// ===== rtl/pdrb_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Set pulldown bit enables pin weak pulldown
// - Clear bit leaves pin to other config
// - Reset sets all eight pulldown bits
// - Readback enable starts read, clears when done
// - Enable zero starts no readback
// - Load mode applied on every write except mode 11 and a software reset
// - Select codes: nop, DAC, ADC, config, reset
// - Mode 00 copies input to DAC immediately
// - Mode 01 holds input, DAC unchanged
// - Mode 10 copies all, updates together
// - GPIO config enables pin seven busy output
module pdrb_regs
	import pdrb_pkg::*;
#(
	parameter int NUM_CH   = 8,
	parameter int DAC_BITS = 12
) (
	// Clocking
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        clk_en,
	// Command words from the serial front end
	input  wire logic                        cmd_valid,
	input  wire logic [CMD_W-1:0]            cmd_word,
	// DAC input register writes
	input  wire logic                        dac_wr_valid,
	input  wire logic [$clog2(NUM_CH)-1:0]   dac_wr_chan,
	input  wire logic [DAC_BITS-1:0]         dac_wr_data,
	// Readback handshake
	input  wire logic                        read_done,
	output logic                             readback_pending,
	output logic [3:0]                       readback_sel,
	output logic                             readback_local,
	output logic [CMD_W-1:0]                 readback_word,
	// Pin configuration, load mode and software reset
	output logic [NUM_CH-1:0]                pulldown_en,
	output logic                             busy_out_en,
	output logic [1:0]                       dac_load_mode,
	output logic                             sw_reset,
	// DAC outputs
	output logic [NUM_CH*DAC_BITS-1:0]       dac_value,
	output logic                             dac_update
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Pin fields are fixed at eight; wider data would not fit a word
	if (NUM_CH != 8) begin : g_bad_num_ch
		$error("pdrb_regs: register layout serves exactly 8 pins");
	end
	if (DAC_BITS < 1 || DAC_BITS > 16) begin : g_bad_dac_bits
		$error("pdrb_regs: DAC_BITS must be 1 to 16");
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire             is_write  = cmd_valid && !cmd_word[CMD_RW_BIT];
	wire [3:0]       cmd_addr  = cmd_word[ADDR_HI:ADDR_LO];
	wire             wr_pd     = is_write && (cmd_addr == ADDR_PULLDOWN);
	wire             wr_rdldac = is_write && (cmd_addr == ADDR_RDLDAC);
	wire             wr_gpio   = is_write && (cmd_addr == ADDR_GPIOCFG);
	wire             rd_en_bit = cmd_word[RD_EN_BIT];
	wire [3:0]       sel_code  = cmd_word[SEL_HI:SEL_LO];
	pdrb_mode_t      mode_code;
	assign mode_code = pdrb_mode_t'(cmd_word[MODE_HI:MODE_LO]);

	// Select codes that start a readback; 0000 and 1110 do nothing
	function automatic logic sel_starts_read(input logic [3:0] s);
		return (s >= SEL_DAC) && (s <= SEL_LASTCFG);
	endfunction

	wire start_read = wr_rdldac && rd_en_bit &&
	                  sel_starts_read(sel_code);
	wire do_swreset = wr_rdldac && rd_en_bit &&
	                  (sel_code == SEL_SWRESET);
	// Undefined mode 11 leaves the stored mode and DAC registers alone
	wire mode_ok    = (mode_code != MODE_UNDEF);
	wire do_copyall = wr_rdldac && (mode_code == MODE_COPYALL);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [NUM_CH-1:0]    pulldown_ff;
	logic [GPIOCFG_W-1:0] gpiocfg_ff;
	pdrb_mode_t           mode_ff;
	logic                 rd_pend_ff;
	logic [3:0]           rd_sel_ff;
	logic                 swreset_ff;

	wire  nxt_rd_pend = start_read ||
	                    (rd_pend_ff && !read_done);

	always_ff @(posedge clk) begin
		if (reset) begin
			pulldown_ff <= PULLDOWN_RST;
			gpiocfg_ff  <= GPIOCFG_RST;
			mode_ff     <= MODE_IMMED;
			rd_pend_ff  <= 1'b0;
			rd_sel_ff   <= SEL_RST;
			swreset_ff  <= 1'b0;
		end else if (clk_en) begin
			swreset_ff <= do_swreset;
			if (do_swreset) begin
				pulldown_ff <= PULLDOWN_RST;
				gpiocfg_ff  <= GPIOCFG_RST;
				mode_ff     <= MODE_IMMED;
				rd_pend_ff  <= 1'b0;
				rd_sel_ff   <= SEL_RST;
			end else begin
				// Reserved bits are simply not stored
				if (wr_pd)
					pulldown_ff <= cmd_word[DATA_HI:DATA_LO];
				if (wr_gpio)
					gpiocfg_ff <= cmd_word[GPIOCFG_W-1:0];
				if (wr_rdldac && mode_ok)
					mode_ff <= mode_code;
				rd_pend_ff <= nxt_rd_pend;
				if (start_read)
					rd_sel_ff <= sel_code;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// A zero bit drives nothing here; the pin is left to other logic
	assign pulldown_en      = pulldown_ff;
	// Busy needs the pin also set as an output
	assign busy_out_en      = gpiocfg_ff[BUSY_EN_BIT] &&
	                          gpiocfg_ff[BUSY_PIN];
	assign dac_load_mode    = mode_ff;
	assign sw_reset         = swreset_ff;
	assign readback_pending = rd_pend_ff;
	assign readback_sel     = rd_sel_ff;
	assign readback_local   = rd_pend_ff &&
	                          ((rd_sel_ff == ADDR_PULLDOWN) ||
	                           (rd_sel_ff == ADDR_RDLDAC)   ||
	                           (rd_sel_ff == ADDR_GPIOCFG));

	// Readback image; reserved positions return zero
	wire [CMD_W-1:0] img_pd    = {8'h00, pulldown_ff};
	wire [CMD_W-1:0] img_rdl   = {9'h000, rd_pend_ff, rd_sel_ff,
	                              mode_ff};
	wire [CMD_W-1:0] img_gpio  = {7'h00, gpiocfg_ff};
	logic [CMD_W-1:0] rb_mux;
	always_comb begin
		if (rd_sel_ff == ADDR_PULLDOWN)
			rb_mux = img_pd;
		else if (rd_sel_ff == ADDR_RDLDAC)
			rb_mux = img_rdl;
		else if (rd_sel_ff == ADDR_GPIOCFG)
			rb_mux = img_gpio;
		else
			rb_mux = '0;
	end

	logic [CMD_W-1:0] rb_word_ff;
	always_ff @(posedge clk) begin
		if (reset)
			rb_word_ff <= '0;
		else if (clk_en)
			rb_word_ff <= rb_mux;
	end
	assign readback_word = rb_word_ff;

	// ------------------------------------------------------------
	// DAC register bank
	// ------------------------------------------------------------
	pdrb_dac_if #(.NUM_CH(NUM_CH), .DAC_BITS(DAC_BITS)) dac_bus ();

	assign dac_bus.wr_valid  = dac_wr_valid;
	assign dac_bus.wr_chan   = dac_wr_chan;
	assign dac_bus.wr_data   = dac_wr_data;
	assign dac_bus.load_mode = mode_ff;
	assign dac_bus.copy_all  = do_copyall;

	pdrb_dac_bank #(
		.NUM_CH   (NUM_CH),
		.DAC_BITS (DAC_BITS)
	) u_bank (
		.clk    (clk),
		.reset  (reset),
		.clk_en (clk_en),
		.dac    (dac_bus.bank)
	);

	assign dac_value  = dac_bus.dac_value;
	assign dac_update = dac_bus.update;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_pd_reset: assert property (@(posedge clk)
		reset |=> pulldown_en == 8'hff)
		else $error("pulldown not all set after reset");

	chk_pd_write: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_pd && !do_swreset |=>
		pulldown_en == $past(cmd_word[7:0]))
		else $error("pulldown write not applied");

	chk_rd_start: assert property (@(posedge clk) disable iff (reset)
		clk_en && start_read |=> readback_pending &&
		readback_sel == $past(sel_code))
		else $error("readback did not start");

	chk_rd_clear: assert property (@(posedge clk) disable iff (reset)
		clk_en && read_done && !start_read && !do_swreset |=>
		!readback_pending)
		else $error("readback enable did not self-clear");

	chk_rd_none: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_rdldac && !rd_en_bit && !rd_pend_ff |=>
		!readback_pending)
		else $error("readback started with enable low");

	chk_sel_undef: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_rdldac && sel_code == 4'he && !rd_pend_ff |=>
		!readback_pending)
		else $error("undefined select started a readback");

	chk_mode_apply: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_rdldac && !do_swreset &&
		cmd_word[1:0] != 2'b11 |=> dac_load_mode == $past(cmd_word[1:0]))
		else $error("load mode not applied");

	chk_mode_undef: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_rdldac && !do_swreset && cmd_word[1:0] == 2'b11 |=>
		$stable(dac_load_mode))
		else $error("mode 11 changed the load mode");

	chk_busy_enable: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_gpio && !do_swreset |=>
		busy_out_en == ($past(cmd_word[8]) && $past(cmd_word[7])))
		else $error("busy enable mismatch");

	chk_sw_reset: assert property (@(posedge clk) disable iff (reset)
		clk_en && do_swreset |=> sw_reset && pulldown_en == 8'hff ##1
		(!sw_reset || !$past(clk_en) || $past(do_swreset)))
		else $error("software reset not performed");

	chk_immed_load: assert property (@(posedge clk) disable iff (reset)
		clk_en && dac_wr_valid && mode_ff == MODE_IMMED && !do_copyall |=>
		dac_update)
		else $error("immediate mode did not update DAC");

	chk_rb_zero: assert property (@(posedge clk) disable iff (reset)
		readback_word[15:11] == 5'h00)
		else $error("reserved readback bits not zero");

	// ------------------------------------------------------------
	// Hold and decode checks
	// ------------------------------------------------------------
	chk_pd_hold: assert property (@(posedge clk) disable iff (reset)
		!(clk_en && (wr_pd || do_swreset)) |=> $stable(pulldown_en))
		else $error("pulldown changed without a write");

	chk_rd_hold: assert property (@(posedge clk) disable iff (reset)
		clk_en && readback_pending && !read_done && !do_swreset |=>
		readback_pending)
		else $error("readback enable cleared before the read finished");

	chk_sel_nop: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_rdldac && sel_code == 4'h0 && !rd_pend_ff |=>
		!readback_pending)
		else $error("select code 0000 started a readback");

	chk_sw_defaults: assert property (@(posedge clk) disable iff (reset)
		clk_en && do_swreset |=> dac_load_mode == 2'b00 &&
		!readback_pending && !busy_out_en)
		else $error("software reset left a register set");

	chk_sw_enable: assert property (@(posedge clk) disable iff (reset)
		clk_en && wr_rdldac && !rd_en_bit |=> !sw_reset)
		else $error("software reset with readback enable low");

	chk_hold_load: assert property (@(posedge clk) disable iff (reset)
		clk_en && dac_wr_valid && mode_ff == MODE_HOLD && !do_copyall |=>
		!dac_update)
		else $error("held mode updated a DAC output");

	chk_rb_image: assert property (@(posedge clk) disable iff (reset)
		clk_en && readback_sel == ADDR_PULLDOWN |=>
		readback_word == {8'h00, $past(pulldown_en)})
		else $error("pulldown readback image wrong");

	chk_busy_hold: assert property (@(posedge clk) disable iff (reset)
		!(clk_en && (wr_gpio || do_swreset)) |=> $stable(busy_out_en))
		else $error("busy enable changed without a write");

	chk_mode_hold: assert property (@(posedge clk) disable iff (reset)
		!(clk_en && wr_rdldac) |=> $stable(dac_load_mode))
		else $error("load mode changed without a write");

endmodule

// ===== sim/pdrb_host.sv
`timescale 1ns/10ps
// Serial host model: forms whole 16-bit command words and strobes them in.
module pdrb_host
	import pdrb_pkg::*;
(
	// Clocking
	input  wire logic          clk,
	// Command port
	output logic               cmd_valid,
	output logic [CMD_W-1:0]   cmd_word
);
	initial begin
		cmd_valid = 1'b0;
		cmd_word  = 16'h0000;
	end

	// ------------------------------------------------------------
	// Word transfer
	// ------------------------------------------------------------
	// Gap lets a slow host idle between words.
	task automatic send(input logic [3:0] addr, input logic [10:0] d,
		input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_word  <= {1'b0, addr, d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_word  <= ~{1'b0, addr, d};
		#1;
	endtask

	task automatic wr_pulldown(input logic [7:0] d);
		send(ADDR_PULLDOWN, {3'h0, d}, 0);
	endtask

	task automatic wr_rdldac(input logic en, input logic [3:0] sel,
		input logic [1:0] mode);
		send(ADDR_RDLDAC, {4'h0, en, sel, mode}, 1);
	endtask

	task automatic wr_gpiocfg(input logic [8:0] d);
		send(ADDR_GPIOCFG, {2'h0, d}, 0);
	endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import pdrb_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic          clk;
	logic          reset;
	logic          clk_en;
	logic          cmd_valid;
	logic [15:0]   cmd_word;
	logic          dac_wr_valid;
	logic [2:0]    dac_wr_chan;
	logic [11:0]   dac_wr_data;
	logic          read_done;
	logic          readback_pending;
	logic [3:0]    readback_sel;
	logic          readback_local;
	logic [15:0]   readback_word;
	logic [7:0]    pulldown_en;
	logic          busy_out_en;
	logic [1:0]    dac_load_mode;
	logic          sw_reset;
	logic [95:0]   dac_value;
	logic          dac_update;
	int            error_cnt;
	int            check_count;

	pdrb_regs #(.NUM_CH(8), .DAC_BITS(12)) pdrb_regs_i (
		.clk              (clk),
		.reset            (reset),
		.clk_en           (clk_en),
		.cmd_valid        (cmd_valid),
		.cmd_word         (cmd_word),
		.dac_wr_valid     (dac_wr_valid),
		.dac_wr_chan      (dac_wr_chan),
		.dac_wr_data      (dac_wr_data),
		.read_done        (read_done),
		.readback_pending (readback_pending),
		.readback_sel     (readback_sel),
		.readback_local   (readback_local),
		.readback_word    (readback_word),
		.pulldown_en      (pulldown_en),
		.busy_out_en      (busy_out_en),
		.dac_load_mode    (dac_load_mode),
		.sw_reset         (sw_reset),
		.dac_value        (dac_value),
		.dac_update       (dac_update)
	);
	pdrb_host pdrb_host_i (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic dac_write(input logic [2:0] ch, input logic [11:0] d);
		@(posedge clk);
		dac_wr_valid <= 1'b1;
		dac_wr_chan  <= ch;
		dac_wr_data  <= d;
		@(posedge clk);
		dac_wr_valid <= 1'b0;
		#1;
	endtask

	task automatic pulse_done();
		@(posedge clk);
		read_done <= 1'b1;
		@(posedge clk);
		read_done <= 1'b0;
		#1;
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset        = 1'b1;
		clk_en       = 1'b1;
		dac_wr_valid = 1'b0;
		dac_wr_chan  = 3'h0;
		dac_wr_data  = 12'h000;
		read_done    = 1'b0;
		error_cnt    = 0;
		check_count  = 0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		check("pulldown", {8'h0, pulldown_en}, 16'h00ff);
		check("pending", {15'h0, readback_pending}, 16'h0000);
		pdrb_host_i.wr_pulldown(8'h55);
		check("pulldown", {8'h0, pulldown_en}, 16'h0055);
		pdrb_host_i.wr_rdldac(1'b1, 4'h6, 2'b01);
		check("pending", {15'h0, readback_pending}, 16'h0001);
		check("sel", {12'h0, readback_sel}, 16'h0006);
		check("mode", {14'h0, dac_load_mode}, 16'h0001);
		@(posedge clk);
		#1;
		check("rb_word", readback_word, 16'h0055);
		pulse_done();
		check("pending", {15'h0, readback_pending}, 16'h0000);
		// Held mode: input register only
		dac_write(3'h3, 12'h456);
		check("update", {15'h0, dac_update}, 16'h0000);
		check("dac3", {4'h0, dac_value[36 +: 12]}, 16'h0000);
		pdrb_host_i.wr_rdldac(1'b0, 4'h0, 2'b10);
		check("update", {15'h0, dac_update}, 16'h0001);
		check("dac3", {4'h0, dac_value[36 +: 12]}, 16'h0456);
		check("pending", {15'h0, readback_pending}, 16'h0000);
		pdrb_host_i.wr_rdldac(1'b0, 4'h0, 2'b11);
		check("mode", {14'h0, dac_load_mode}, 16'h0002);
		pdrb_host_i.wr_rdldac(1'b0, 4'h5, 2'b00);
		check("mode", {14'h0, dac_load_mode}, 16'h0000);
		dac_write(3'h2, 12'h123);
		check("update", {15'h0, dac_update}, 16'h0001);
		check("dac2", {4'h0, dac_value[24 +: 12]}, 16'h0123);
		// Every readback code that starts a readback
		for (int s = 1; s <= 13; s++) begin
			pdrb_host_i.wr_rdldac(1'b1, 4'(s), 2'b00);
			check("pending", {15'h0, readback_pending}, 16'h0001);
			check("sel", {12'h0, readback_sel}, 16'(s));
			check("local", {15'h0, readback_local},
				16'(s >= 6 && s <= 8));
			pulse_done();
		end
		pdrb_host_i.wr_rdldac(1'b1, 4'h0, 2'b00);
		check("pending", {15'h0, readback_pending}, 16'h0000);
		pdrb_host_i.wr_rdldac(1'b1, 4'he, 2'b00);
		check("pending", {15'h0, readback_pending}, 16'h0000);
		pdrb_host_i.wr_gpiocfg(9'h180);
		check("busy", {15'h0, busy_out_en}, 16'h0001);
		pdrb_host_i.wr_rdldac(1'b1, 4'h8, 2'b00);
		@(posedge clk);
		#1;
		check("rb_word", readback_word, 16'h0180);
		pulse_done();
		pdrb_host_i.wr_gpiocfg(9'h100);
		check("busy", {15'h0, busy_out_en}, 16'h0000);
		pdrb_host_i.wr_gpiocfg(9'h180);
		pdrb_host_i.wr_rdldac(1'b1, 4'hf, 2'b00);
		check("swreset", {15'h0, sw_reset}, 16'h0001);
		@(posedge clk);
		#1;
		check("pulldown", {8'h0, pulldown_en}, 16'h00ff);
		check("busy", {15'h0, busy_out_en}, 16'h0000);
		// Clock enable low: a command in that window is lost
		@(posedge clk);
		clk_en <= 1'b0;
		pdrb_host_i.wr_pulldown(8'h0f);
		check("pulldown", {8'h0, pulldown_en}, 16'h00ff);
		@(posedge clk);
		clk_en <= 1'b1;
		pdrb_host_i.wr_pulldown(8'h0f);
		check("pulldown", {8'h0, pulldown_en}, 16'h000f);
		// Reset in mid-run restores the all-set pulldowns
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		#1;
		check("pulldown", {8'h0, pulldown_en}, 16'h00ff);
		report_and_stop();
	end
endmodule
